// [logic/vbd_pkg.sv]
`default_nettype none
package vbd_pkg;
    // local cpu bus map
    localparam logic [31:0] ADDR_CNT_LONG = 32'hFE60_0000;
    localparam logic [31:0] ADDR_CNT_DBL = 32'hFE60_0020;
    localparam logic [31:0] ADDR_STATUS = 32'hFE38_0002;
    localparam logic [31:0] ADDR_PAUSE = 32'h0000_0000;
    localparam int STATUS_OK_BIT = 4;
    localparam int CNT_MSB = 9;
    localparam int CNT_W = 10;
    localparam int BEAT_W = 8;
    // function codes carried by the setup cycles
    localparam logic [2:0] FC_SUPER = 3'h4;
    localparam logic [2:0] FC_USER = 3'h0;
    // address steps per beat
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;
    localparam logic [31:0] STEP_DBL = 32'h0000_0008;
    // software-side limits, in bytes
    localparam logic [11:0] MIN_LONG = 12'h008;
    localparam logic [11:0] MIN_DBL = 12'h010;
    localparam logic [11:0] MAX_LONG = 12'h3FC;
    localparam logic [11:0] MAX_DBL = 12'h7F0;
    localparam logic [11:0] PAGE_BYTES = 12'h800;
    localparam int PAGE_LSB_W = 11;
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// [logic/vbd_cpu_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface vbd_cpu_if;
    logic req;
    logic we;
    logic alt;
    logic [2:0] fc;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic irq_mask;
    modport dev (input req, input we, input alt, input fc, input addr, input wdata,
                 output rdata, output ack, output irq_mask);
    modport cpu (output req, output we, output alt, output fc, output addr, output wdata,
                 input rdata, input ack, input irq_mask);
endinterface
`default_nettype wire

// [logic/vbd_engine.sv]
`timescale 1ns/1ps
`default_nettype none
module vbd_engine (
    input wire logic clk_sys, // 25 MHz
    input wire logic nrst, // async reset
    vbd_cpu_if.dev cpu, // local cpu bus
    output logic vme_req, // vme beat request
    output logic [31:0] vme_addr, // vme beat address
    output logic vme_blk, // block beat, else single setup read
    output logic vme_dbl, // 64-bit beat
    output logic vme_super, // supervisor space
    input wire logic [63:0] vme_rdata, // beat data
    input wire logic vme_ack, // beat done
    input wire logic vme_berr, // bus error
    output logic ram_we, // ram write pulse
    output logic [31:0] ram_addr, // ram address
    output logic [63:0] ram_wdata, // ram data
    output logic ram_dbl, // 64-bit write
    output logic busy, // engine not idle
    output logic status_ok // last block ok
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ARMED = 5'b00010,
        ST_SETUP_RD = 5'b00100,
        ST_WAIT_WR = 5'b01000,
        ST_XFER = 5'b10000
    } vbd_state_e;

    vbd_state_e state_reg, state_next;
    logic [vbd_pkg::BEAT_W-1:0] beats_reg, beats_next;
    logic dbl_reg, dbl_next;
    logic super_reg, super_next;
    logic ok_reg, ok_next;
    logic mask_reg, mask_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] vaddr_reg, vaddr_next;
    logic [31:0] laddr_reg, laddr_next;
    logic ram_we_reg, ram_we_next;
    logic [31:0] ram_addr_reg, ram_addr_next;
    logic [63:0] ram_wdata_reg, ram_wdata_next;

    logic take;
    logic ordinary;
    logic cnt_long;
    logic cnt_dbl;
    logic stat_rd;
    logic [31:0] step;
    logic [31:0] stat_word;

    // one cycle per request: ack pulse blocks a second take of the same cycle
    assign take = cpu.req && !ack_reg;
    assign ordinary = take && !cpu.alt;
    assign cnt_long = ordinary && cpu.we && (cpu.addr == vbd_pkg::ADDR_CNT_LONG);
    assign cnt_dbl = ordinary && cpu.we && (cpu.addr == vbd_pkg::ADDR_CNT_DBL);
    assign stat_rd = ordinary && !cpu.we && (cpu.addr == vbd_pkg::ADDR_STATUS);
    assign step = dbl_reg ? vbd_pkg::STEP_DBL : vbd_pkg::STEP_LONG;

    always_comb
    begin
        stat_word = vbd_pkg::STATUS_RST;
        stat_word[vbd_pkg::STATUS_OK_BIT] = ok_reg;
    end

    always_comb
    begin
        state_next = state_reg;
        beats_next = beats_reg;
        dbl_next = dbl_reg;
        super_next = super_reg;
        ok_next = ok_reg;
        mask_next = mask_reg;
        ack_next = 1'b0;
        rdata_next = rdata_reg;
        vaddr_next = vaddr_reg;
        laddr_next = laddr_reg;
        ram_we_next = 1'b0;
        ram_addr_next = ram_addr_reg;
        ram_wdata_next = ram_wdata_reg;
        case (state_reg)
            ST_IDLE:
            begin
                // plain cycles other than count writes, alternate ones included, are answered and ignored
                if (take)
                begin
                    ack_next = 1'b1;
                    rdata_next = stat_rd ? stat_word : vbd_pkg::STATUS_RST;
                end
                if (cnt_long)
                begin
                    // bits 1:0 dropped, bits 31:10 ignored
                    beats_next = cpu.wdata[vbd_pkg::CNT_MSB:2];
                    dbl_next = 1'b0;
                    mask_next = 1'b1;
                    state_next = ST_ARMED;
                end
                else if (cnt_dbl)
                begin
                    // count in words, truncated to 8; two longword pairs per 8 words
                    beats_next = {cpu.wdata[vbd_pkg::CNT_MSB:3], 1'b0};
                    dbl_next = 1'b1;
                    mask_next = 1'b1;
                    state_next = ST_ARMED;
                end
            end
            ST_ARMED:
            begin
                if (take && cpu.alt && !cpu.we)
                begin
                    // first setup cycle: vme source, read direction
                    vaddr_next = cpu.addr;
                    super_next = (cpu.fc == vbd_pkg::FC_SUPER);
                    state_next = ST_SETUP_RD;
                end
                else if (take)
                begin
                    // out-of-order or plain cycles pass untouched
                    ack_next = 1'b1;
                    rdata_next = stat_rd ? stat_word : vbd_pkg::STATUS_RST;
                end
            end
            ST_SETUP_RD:
            begin
                if (vme_berr)
                begin
                    ok_next = 1'b0;
                    mask_next = 1'b0;
                    ack_next = 1'b1;
                    rdata_next = vbd_pkg::STATUS_RST;
                    state_next = ST_IDLE;
                end
                else if (vme_ack)
                begin
                    ack_next = 1'b1;
                    rdata_next = vme_rdata[31:0];
                    state_next = ST_WAIT_WR;
                end
            end
            ST_WAIT_WR:
            begin
                if (take)
                begin
                    ack_next = 1'b1;
                    rdata_next = stat_rd ? stat_word : vbd_pkg::STATUS_RST;
                end
                if (take && cpu.alt && cpu.we)
                begin
                    laddr_next = cpu.addr;
                    if (beats_reg == '0)
                    begin
                        // nothing to move: finish at once
                        ok_next = 1'b1;
                        mask_next = 1'b0;
                        state_next = ST_IDLE;
                    end
                    else
                    begin
                        state_next = ST_XFER;
                    end
                end
            end
            ST_XFER:
            begin
                // cpu cycles wait here unanswered: the local bus is ours
                if (vme_berr)
                begin
                    ok_next = 1'b0;
                    mask_next = 1'b0;
                    state_next = ST_IDLE;
                end
                else if (vme_ack)
                begin
                    ram_we_next = 1'b1;
                    ram_addr_next = laddr_reg;
                    ram_wdata_next = vme_rdata;
                    vaddr_next = vaddr_reg + step;
                    laddr_next = laddr_reg + step;
                    beats_next = beats_reg - 1'b1;
                    if (beats_reg == 1'b1)
                    begin
                        ok_next = 1'b1;
                        mask_next = 1'b0;
                        state_next = ST_IDLE;
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
                mask_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ST_IDLE;
            beats_reg <= '0;
            dbl_reg <= 1'b0;
            super_reg <= 1'b0;
            ok_reg <= 1'b0;
            mask_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdata_reg <= vbd_pkg::STATUS_RST;
            vaddr_reg <= '0;
            laddr_reg <= '0;
            ram_we_reg <= 1'b0;
            ram_addr_reg <= '0;
            ram_wdata_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            beats_reg <= beats_next;
            dbl_reg <= dbl_next;
            super_reg <= super_next;
            ok_reg <= ok_next;
            mask_reg <= mask_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            vaddr_reg <= vaddr_next;
            laddr_reg <= laddr_next;
            ram_we_reg <= ram_we_next;
            ram_addr_reg <= ram_addr_next;
            ram_wdata_reg <= ram_wdata_next;
        end
    end

    assign cpu.ack = ack_reg;
    assign cpu.rdata = rdata_reg;
    assign cpu.irq_mask = mask_reg;
    // request held through a whole block; each ack cycle is one beat
    assign vme_req = (state_reg == ST_SETUP_RD) || (state_reg == ST_XFER);
    assign vme_addr = vaddr_reg;
    assign vme_blk = (state_reg == ST_XFER);
    assign vme_dbl = dbl_reg && (state_reg == ST_XFER);
    assign vme_super = super_reg;
    assign ram_we = ram_we_reg;
    assign ram_addr = ram_addr_reg;
    assign ram_wdata = ram_wdata_reg;
    assign ram_dbl = dbl_reg;
    assign busy = (state_reg != ST_IDLE);
    assign status_ok = ok_reg;
endmodule
`default_nettype wire

// [logic/vbd_cpu_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module vbd_cpu_seq (
    input wire logic clk_sys, // 25 MHz
    input wire logic nrst, // async reset
    input wire logic cmd_valid, // block request
    output logic cmd_ready, // sequencer idle
    input wire logic cmd_dbl, // double-longword mode
    input wire logic [11:0] cmd_bytes, // block length in bytes
    input wire logic [31:0] cmd_vme_addr, // vme source
    input wire logic [31:0] cmd_ram_addr, // ram target
    input wire logic cmd_super, // supervisor space
    output logic done, // one-cycle completion pulse
    output logic done_ok, // engine reported success
    output logic done_rej, // request refused by checks
    vbd_cpu_if.cpu cpu // local cpu bus
);
    typedef enum logic [6:0] {
        SQ_IDLE = 7'b0000001,
        SQ_ARM = 7'b0000010,
        SQ_PAUSE = 7'b0000100,
        SQ_SRD = 7'b0001000,
        SQ_SWR = 7'b0010000,
        SQ_STAT = 7'b0100000,
        SQ_DONE = 7'b1000000
    } vbd_seq_e;

    vbd_seq_e state_reg, state_next;
    logic dbl_reg, dbl_next;
    logic [11:0] bytes_reg, bytes_next;
    logic [31:0] vaddr_reg, vaddr_next;
    logic [31:0] laddr_reg, laddr_next;
    logic super_reg, super_next;
    logic [31:0] data_reg, data_next;
    logic ok_reg, ok_next;
    logic rej_reg, rej_next;

    logic [2:0] amask;
    logic [11:0] min_b;
    logic [11:0] max_b;
    logic [11:0] vend;
    logic [11:0] lend;
    logic legal;
    logic [31:0] cnt_word;

    always_comb
    begin
        amask = cmd_dbl ? 3'h7 : 3'h3;
        min_b = cmd_dbl ? vbd_pkg::MIN_DBL : vbd_pkg::MIN_LONG;
        max_b = cmd_dbl ? vbd_pkg::MAX_DBL : vbd_pkg::MAX_LONG;
        vend = {1'b0, cmd_vme_addr[vbd_pkg::PAGE_LSB_W-1:0]} + cmd_bytes;
        lend = {1'b0, cmd_ram_addr[vbd_pkg::PAGE_LSB_W-1:0]} + cmd_bytes;
        legal = ((cmd_vme_addr[2:0] & amask) == 3'h0)
            && ((cmd_vme_addr[2:0] ^ cmd_ram_addr[2:0]) == 3'h0)
            && ((cmd_bytes[2:0] & amask) == 3'h0)
            && (cmd_bytes >= min_b) && (cmd_bytes <= max_b)
            && (vend <= vbd_pkg::PAGE_BYTES) && (lend <= vbd_pkg::PAGE_BYTES);
    end

    // double mode takes a word count, so the byte length is halved
    always_comb
    begin
        cnt_word = '0;
        cnt_word[vbd_pkg::CNT_W-1:0] = dbl_reg ? bytes_reg[vbd_pkg::CNT_W:1]
                                               : bytes_reg[vbd_pkg::CNT_W-1:0];
    end

    always_comb
    begin
        state_next = state_reg;
        dbl_next = dbl_reg;
        bytes_next = bytes_reg;
        vaddr_next = vaddr_reg;
        laddr_next = laddr_reg;
        super_next = super_reg;
        data_next = data_reg;
        ok_next = ok_reg;
        rej_next = rej_reg;
        case (state_reg)
            SQ_IDLE:
            begin
                if (cmd_valid)
                begin
                    dbl_next = cmd_dbl;
                    bytes_next = cmd_bytes;
                    vaddr_next = cmd_vme_addr;
                    laddr_next = cmd_ram_addr;
                    super_next = cmd_super;
                    ok_next = 1'b0;
                    rej_next = !legal;
                    state_next = legal ? SQ_ARM : SQ_DONE;
                end
            end
            SQ_ARM:
            begin
                if (cpu.ack)
                begin
                    state_next = SQ_PAUSE;
                end
            end
            SQ_PAUSE:
            begin
                // harmless cycle lets a pending interrupt in before setup
                if (cpu.ack)
                begin
                    state_next = SQ_SRD;
                end
            end
            SQ_SRD:
            begin
                if (cpu.ack)
                begin
                    data_next = cpu.rdata;
                    state_next = SQ_SWR;
                end
            end
            SQ_SWR:
            begin
                if (cpu.ack)
                begin
                    state_next = SQ_STAT;
                end
            end
            SQ_STAT:
            begin
                if (cpu.ack)
                begin
                    ok_next = cpu.rdata[vbd_pkg::STATUS_OK_BIT];
                    state_next = SQ_DONE;
                end
            end
            SQ_DONE:
            begin
                state_next = SQ_IDLE;
            end
            default:
            begin
                state_next = SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= SQ_IDLE;
            dbl_reg <= 1'b0;
            bytes_reg <= '0;
            vaddr_reg <= '0;
            laddr_reg <= '0;
            super_reg <= 1'b0;
            data_reg <= '0;
            ok_reg <= 1'b0;
            rej_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            dbl_reg <= dbl_next;
            bytes_reg <= bytes_next;
            vaddr_reg <= vaddr_next;
            laddr_reg <= laddr_next;
            super_reg <= super_next;
            data_reg <= data_next;
            ok_reg <= ok_next;
            rej_reg <= rej_next;
        end
    end

    always_comb
    begin
        cpu.req = 1'b0;
        cpu.we = 1'b0;
        cpu.alt = 1'b0;
        cpu.addr = vbd_pkg::ADDR_PAUSE;
        cpu.wdata = '0;
        cpu.fc = super_reg ? vbd_pkg::FC_SUPER : vbd_pkg::FC_USER;
        case (state_reg)
            SQ_ARM:
            begin
                cpu.req = !cpu.ack;
                cpu.we = 1'b1;
                cpu.addr = dbl_reg ? vbd_pkg::ADDR_CNT_DBL : vbd_pkg::ADDR_CNT_LONG;
                cpu.wdata = cnt_word;
            end
            SQ_PAUSE:
            begin
                cpu.req = !cpu.ack;
            end
            SQ_SRD:
            begin
                cpu.req = !cpu.ack;
                cpu.alt = 1'b1;
                cpu.addr = vaddr_reg;
            end
            SQ_SWR:
            begin
                cpu.req = !cpu.ack;
                cpu.we = 1'b1;
                cpu.alt = 1'b1;
                cpu.addr = laddr_reg;
                cpu.wdata = data_reg;
            end
            SQ_STAT:
            begin
                cpu.req = !cpu.ack;
                cpu.addr = vbd_pkg::ADDR_STATUS;
            end
            default:
            begin
                cpu.req = 1'b0;
            end
        endcase
    end

    assign cmd_ready = (state_reg == SQ_IDLE);
    assign done = (state_reg == SQ_DONE);
    assign done_ok = ok_reg;
    assign done_rej = rej_reg;
endmodule
`default_nettype wire

// [sim/vbd_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module vbd_sva (
    input wire logic clk_sys, // bus clock
    input wire logic nrst, // async reset
    input wire logic req, // cycle requested
    input wire logic we, // write cycle
    input wire logic alt, // alternate-space cycle
    input wire logic [2:0] fc, // function code
    input wire logic [31:0] addr, // cycle address
    input wire logic [31:0] wdata, // write data
    input wire logic [31:0] rdata, // read data
    input wire logic ack, // cycle answered
    input wire logic irq_mask // interrupts masked
);
    logic rd_seen_reg, rd_seen_next;
    logic [11:0] mask_cnt_reg, mask_cnt_next;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    always_comb
    begin
        rd_seen_next = rd_seen_reg;
        // the cpu end drops req while ack stands, so the answer alone marks the cycle
        if (ack && alt)
            rd_seen_next = !we;
        mask_cnt_next = irq_mask ? mask_cnt_reg + 12'h001 : 12'h000;
    end
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_seen_reg <= 1'b0;
            mask_cnt_reg <= 12'h000;
        end
        else
        begin
            rd_seen_reg <= rd_seen_next;
            mask_cnt_reg <= mask_cnt_next;
        end
    end
    sequence cnt_take;
        req && !ack && we && !alt
            && (addr == vbd_pkg::ADDR_CNT_LONG || addr == vbd_pkg::ADDR_CNT_DBL);
    endsequence
    sequence pause_take;
        req && !ack && !we && !alt && addr == vbd_pkg::ADDR_PAUSE;
    endsequence
    arm_mask_a: assert property (cnt_take |=> ack && irq_mask)
        else $error("count write did not mask interrupts");
    mask_cause_a: assert property ($rose(irq_mask) |->
        $past(req && we && !alt && (addr == vbd_pkg::ADDR_CNT_LONG
        || addr == vbd_pkg::ADDR_CNT_DBL))) else $error("mask rose without count write");
    pause_zero_a: assert property (pause_take |=> ack && rdata == 32'h0000_0000)
        else $error("pause read not answered with zero");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack |-> $past(req))
        else $error("ack without request");
    req_hold_a: assert property (req && !ack |=>
        ack || (req && $stable({we, alt, fc, addr, wdata})))
        else $error("request changed before ack");
    setup_order_a: assert property (req && alt && we |-> rd_seen_reg)
        else $error("setup write before setup read");
    fc_space_a: assert property (req && alt |->
        fc == vbd_pkg::FC_SUPER || fc == vbd_pkg::FC_USER)
        else $error("setup cycle with bad function code");
    mask_bound_a: assert property (irq_mask |-> mask_cnt_reg < 12'h4B0)
        else $error("interrupts masked too long");
    status_quiet_a: assert property (ack && !we && !alt && addr == vbd_pkg::ADDR_STATUS
        |-> !irq_mask) else $error("status answered during block");
endmodule
`default_nettype wire

// [sim/vbd_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module vme_block_read_dma_tb_top;
    logic clk_sys, nrst, cmd_valid, cmd_dbl, cmd_super, cmd_ready, done, done_ok, done_rej;
    logic [11:0] cmd_bytes;
    logic [31:0] cmd_vme_addr, cmd_ram_addr;
    logic vme_ack, vme_berr, stall, act, go, last_dbl, last_sup;
    logic [63:0] vme_rdata;
    logic [1:0] v_req, v_blk, v_dbl, v_sup, r_we, r_dbl, busy, ok;
    logic [31:0] v_addr [2];
    logic [31:0] r_addr [2];
    logic [63:0] r_data [2];
    logic [63:0] got_q [$];
    logic [31:0] gaddr_q [$];
    int miscompares, checks, beat_n, berr_at;
    vbd_cpu_if bus [2] ();
    vbd_cpu_seq vbd_cpu_seq_i (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_dbl(cmd_dbl), .cmd_bytes(cmd_bytes),
        .cmd_vme_addr(cmd_vme_addr), .cmd_ram_addr(cmd_ram_addr), .cmd_super(cmd_super),
        .done(done), .done_ok(done_ok), .done_rej(done_rej), .cpu(bus[0].cpu));
    // second engine is driven straight from the bench to break the setup order
    for (genvar g = 0; g < 2; g++)
    begin : eng
        vbd_engine vbd_engine_i (.clk_sys(clk_sys), .nrst(nrst), .cpu(bus[g].dev),
            .vme_req(v_req[g]), .vme_addr(v_addr[g]), .vme_blk(v_blk[g]), .vme_dbl(v_dbl[g]),
            .vme_super(v_sup[g]), .vme_rdata(vme_rdata), .vme_ack(vme_ack),
            .vme_berr(vme_berr), .ram_we(r_we[g]), .ram_addr(r_addr[g]),
            .ram_wdata(r_data[g]), .ram_dbl(r_dbl[g]), .busy(busy[g]), .status_ok(ok[g]));
    end
    vbd_sva vbd_sva_i (.clk_sys(clk_sys), .nrst(nrst), .req(bus[0].req), .we(bus[0].we),
        .alt(bus[0].alt), .fc(bus[0].fc), .addr(bus[0].addr), .wdata(bus[0].wdata),
        .rdata(bus[0].rdata), .ack(bus[0].ack), .irq_mask(bus[0].irq_mask));
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // shared slave: data carries its own address so every ram beat is traceable
    always
    begin
        @(posedge clk_sys);
        act = v_req[1];
        if (v_req[act] && vme_ack)
        begin
            beat_n++;
            if (v_blk[act])
                {last_dbl, last_sup} = {v_dbl[act], v_sup[act]};
        end
        #1;
        act = v_req[1];
        go = v_req[act] && (!stall || !vme_ack);
        vme_berr = go && beat_n == berr_at;
        vme_ack = go && beat_n != berr_at;
        vme_rdata = {~v_addr[act], v_addr[act]};
    end
    always @(posedge clk_sys)
    begin
        if (|r_we)
        begin
            gaddr_q.push_back(r_addr[r_we[1]]);
            got_q.push_back(r_dbl[r_we[1]] ? r_data[r_we[1]] : {32'h0, r_data[r_we[1]][31:0]});
        end
    end
    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic guard(input int n, input int lim);
        if (n >= lim)
        begin
            miscompares++;
            results;
        end
    endtask
    task automatic run_cmd(input logic dbl, input logic [11:0] bytes, input logic [31:0] va,
        input logic [31:0] ra, input logic sup, input int err, input logic rej);
        int n;
        int step;
        logic [31:0] a;
        berr_at = err;
        beat_n = 0;
        got_q.delete();
        gaddr_q.delete();
        {cmd_dbl, cmd_bytes, cmd_vme_addr, cmd_ram_addr, cmd_super} = {dbl, bytes, va, ra, sup};
        cmd_valid = 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (!cmd_ready && n < 20);
        guard(n, 20);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        while (!done && n < 3000)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        guard(n, 3000);
        check_val(done_rej, rej);
        if (rej)
            return;
        step = dbl ? 8 : 4;
        n = (err < 0) ? bytes / step : ((err > 0) ? err - 1 : 0);
        check_val(got_q.size(), n);
        for (int i = 0; i < n && i < got_q.size(); i++)
        begin
            a = va + i * step;
            check_val(gaddr_q[i], ra + i * step);
            check_val(got_q[i], dbl ? {~a, a} : {32'h0, a});
        end
        check_val({done_ok, ok[0]}, (err < 0) ? 2'h3 : 2'h0);
        if (n > 0)
            check_val({last_dbl, last_sup}, {dbl, sup});
    endtask
    task automatic bus_b(input logic w, input logic a, input logic [31:0] ad,
        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        #1;
        {bus[1].we, bus[1].alt, bus[1].addr, bus[1].wdata, bus[1].req} = {w, a, ad, wd, 1'b1};
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (!bus[1].ack && n < 2000);
        rd = bus[1].rdata;
        guard(n, 2000);
        #1;
        bus[1].req = 1'b0;
    endtask
    task automatic blk_b(input logic [31:0] ca, input logic [31:0] cnt, input int beats);
        logic [31:0] rd;
        berr_at = -1;
        got_q.delete();
        gaddr_q.delete();
        bus_b(1'b1, 1'b0, ca, cnt, rd);
        check_val(bus[1].irq_mask, 1'b1);
        bus_b(1'b0, 1'b0, vbd_pkg::ADDR_PAUSE, 32'h0, rd);
        check_val(rd, 32'h0);
        bus_b(1'b1, 1'b1, 32'h4000_0000, 32'h0, rd);
        check_val(v_req[1], 1'b0);
        bus_b(1'b0, 1'b1, 32'h3000_0000, 32'h0, rd);
        check_val(rd, 32'h3000_0000);
        bus_b(1'b1, 1'b1, 32'h4000_0000, rd, rd);
        bus_b(1'b0, 1'b0, vbd_pkg::ADDR_STATUS, 32'h0, rd);
        check_val({rd[vbd_pkg::STATUS_OK_BIT], bus[1].irq_mask, busy[1]}, 3'h4);
        check_val(got_q.size(), beats);
        check_val(gaddr_q[beats - 1], 32'h4000_0000 + (beats - 1) * (ca[5] ? 8 : 4));
        bus_b(1'b0, 1'b1, 32'h3000_0000, 32'h0, rd);
        check_val({rd, v_req[1]}, 33'h0);
    endtask
    initial
    begin
        {nrst, cmd_valid, cmd_dbl, cmd_super, cmd_bytes, cmd_vme_addr, cmd_ram_addr} = '0;
        {vme_ack, vme_berr, vme_rdata, stall, last_dbl, last_sup} = '0;
        {bus[1].req, bus[1].we, bus[1].alt, bus[1].addr, bus[1].wdata} = '0;
        bus[1].fc = vbd_pkg::FC_USER;
        berr_at = -1;
        repeat (2) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        run_cmd(1'b0, 12'h008, 32'h1000_0000, 32'h0008_0000, 1'b1, -1, 1'b0);
        stall = 1'b1;
        run_cmd(1'b0, 12'h3FC, 32'h1000_0800, 32'h0008_0800, 1'b0, -1, 1'b0);
        run_cmd(1'b1, 12'h7F0, 32'h2000_0000, 32'h0009_0000, 1'b1, -1, 1'b0);
        stall = 1'b0;
        run_cmd(1'b1, 12'h010, 32'h2000_0800, 32'h0009_0800, 1'b0, -1, 1'b0);
        run_cmd(1'b0, 12'h040, 32'h1000_1000, 32'h0008_1000, 1'b1, 3, 1'b0);
        run_cmd(1'b1, 12'h020, 32'h2000_1000, 32'h0009_1000, 1'b1, 0, 1'b0);
        run_cmd(1'b0, 12'h010, 32'h1000_2000, 32'h0008_2000, 1'b0, -1, 1'b0);
        run_cmd(1'b0, 12'h004, 32'h1000_0000, 32'h0008_0000, 1'b1, -1, 1'b1);
        run_cmd(1'b1, 12'h008, 32'h1000_0000, 32'h0008_0000, 1'b1, -1, 1'b1);
        run_cmd(1'b0, 12'h00A, 32'h1000_0000, 32'h0008_0000, 1'b1, -1, 1'b1);
        run_cmd(1'b0, 12'h008, 32'h1000_0002, 32'h0008_0002, 1'b1, -1, 1'b1);
        run_cmd(1'b0, 12'h008, 32'h1000_0004, 32'h0008_0000, 1'b1, -1, 1'b1);
        run_cmd(1'b0, 12'h010, 32'h1000_07F8, 32'h0008_0000, 1'b1, -1, 1'b1);
        run_cmd(1'b0, 12'h400, 32'h1000_0000, 32'h0008_0000, 1'b1, -1, 1'b1);
        blk_b(vbd_pkg::ADDR_CNT_LONG, 32'h0000_000B, 2);
        blk_b(vbd_pkg::ADDR_CNT_DBL, 32'h0000_001F, 6);
        results;
    end
endmodule
`default_nettype wire
